// [rtl/fpp_pkg.sv]
// Constants and types shared by the four phase fetch and execute pipeline.
package fpp_pkg;
  localparam int unsigned FPP_PHASES = 4;
  localparam int unsigned FPP_ADDR_W = 11;
  localparam int unsigned FPP_INSTR_W = 15;
  localparam int unsigned FPP_DATA_W = 8;
  localparam logic [10:0] FPP_RESET_PC = 11'h000;
  localparam logic [14:0] FPP_NOP_WORD = 15'h0000;
  // Opcode field sits in the top four bits of the instruction word.
  localparam int unsigned FPP_OP_MSB = 14;
  localparam int unsigned FPP_OP_LSB = 11;
  localparam logic [3:0] FPP_OP_NOP = 4'h0;
  localparam logic [3:0] FPP_OP_LDI = 4'h1;
  localparam logic [3:0] FPP_OP_ADD = 4'h2;
  localparam logic [3:0] FPP_OP_SUB = 4'h3;
  localparam logic [3:0] FPP_OP_AND = 4'h4;
  localparam logic [3:0] FPP_OP_OR = 4'h5;
  localparam logic [3:0] FPP_OP_XOR = 4'h6;
  localparam logic [3:0] FPP_OP_RL = 4'h7;
  localparam logic [3:0] FPP_OP_RR = 4'h8;
  localparam logic [3:0] FPP_OP_INC = 4'h9;
  localparam logic [3:0] FPP_OP_DEC = 4'hA;
  localparam logic [3:0] FPP_OP_SZ = 4'hB;
  localparam logic [3:0] FPP_OP_JMP = 4'hC;
  localparam logic [3:0] FPP_OP_CALL = 4'hD;
  localparam logic [3:0] FPP_OP_RET = 4'hE;

  // Gray sequence along the phase ring.
  typedef enum logic [1:0] {
    FPP_FETCH_PHASE = 2'h0,
    FPP_DECODE_PHASE = 2'h1,
    FPP_EXEC_PHASE = 2'h3,
    FPP_WRITE_PHASE = 2'h2
  } fpp_phase_t;
endpackage

// [rtl/fpp_alu_if.sv]
// Interface carrying operands and results between sequencer and ALU.
`timescale 1ns/1ps
interface fpp_alu_if;
  logic [3:0] op;
  logic [7:0] acc;
  logic [7:0] imm;
  logic [7:0] result;
  logic zero;
  modport seq (output op, output acc, output imm, input result, input zero);
  modport alu (input op, input acc, input imm, output result, output zero);
endinterface

// [rtl/fpp_alu.sv]
// Eight bit arithmetic and logic unit.
`timescale 1ns/1ps
module fpp_alu
  import fpp_pkg::*;
(
  fpp_alu_if.alu bus
);
  always_comb begin
    case (bus.op)
      FPP_OP_LDI: bus.result = bus.imm;
      FPP_OP_ADD: bus.result = bus.acc + bus.imm;
      FPP_OP_SUB: bus.result = bus.acc - bus.imm;
      FPP_OP_AND: bus.result = bus.acc & bus.imm;
      FPP_OP_OR: bus.result = bus.acc | bus.imm;
      FPP_OP_XOR: bus.result = bus.acc ^ bus.imm;
      FPP_OP_RL: bus.result = {bus.acc[6:0], bus.acc[7]};
      FPP_OP_RR: bus.result = {bus.acc[0], bus.acc[7:1]};
      FPP_OP_INC: bus.result = bus.acc + 8'h01;
      FPP_OP_DEC: bus.result = bus.acc - 8'h01;
      default: bus.result = bus.acc;
    endcase
  end

  // Branch decision: skip condition tests the accumulator for zero.
  assign bus.zero = (bus.acc == 8'h00);
endmodule // fpp_alu

// [rtl/fpp_pipeline.sv]
// Four phase fetch and execute pipeline sequencer for a small 8-bit core.
//
// Summary of operation
// - Four non-overlapping phases are derived from the system clock and one pass is one cycle.
// - The program counter advances at the end of the fetch phase, when the fetched word is sampled.
// - Decode and execution take place in the cycle after the fetch cycle, in its execute phase.
// - The next fetch overlaps execution of the current word, giving one word per cycle.
// - Jumps, calls and returns take two cycles: one to get the target and one to branch.
// - An 8-bit ALU carries data through the accumulator; NOP, SZ, JMP, CALL and RET leave it unchanged.
// - A taken skip discards the prefetched word and runs a dummy cycle instead.
`timescale 1ns/1ps
module fpp_pipeline
  import fpp_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = 6
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [14:0] instr_word_i,
  output logic [10:0] fetch_addr_o,
  output logic fetch_strobe_o,
  output logic [3:0] phase_o,
  output logic [7:0] acc_o,
  output logic zero_flag_o,
  output logic flush_o
);
  // ---------------------------------------------------------------
  // Phase ring
  // ---------------------------------------------------------------
  fpp_phase_t phase_r;
  fpp_phase_t phase_nxt;

  always_comb begin
    case (phase_r)
      FPP_FETCH_PHASE: phase_nxt = FPP_DECODE_PHASE;
      FPP_DECODE_PHASE: phase_nxt = FPP_EXEC_PHASE;
      FPP_EXEC_PHASE: phase_nxt = FPP_WRITE_PHASE;
      FPP_WRITE_PHASE: phase_nxt = FPP_FETCH_PHASE;
      default: phase_nxt = FPP_FETCH_PHASE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_r <= FPP_FETCH_PHASE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  logic [3:0] phase_oh_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_oh_r <= 4'h1;
    end else begin
      phase_oh_r <= {phase_oh_r[2:0], phase_oh_r[3]};
    end
  end
  assign phase_o = phase_oh_r;

  wire logic in_fetch = (phase_r == FPP_FETCH_PHASE);
  wire logic in_exec = (phase_r == FPP_EXEC_PHASE);
  wire logic end_cycle = (phase_r == FPP_WRITE_PHASE);

  // ---------------------------------------------------------------
  // Fetch and program counter
  // ---------------------------------------------------------------
  logic [10:0] pc_r;
  logic [14:0] ir_r;
  logic ir_valid_r;
  logic branch_pend_r;
  logic [10:0] target_r;
  logic redirect_r;
  logic [10:0] redirect_pc_r;
  logic kill_r;
  logic [14:0] pf_r;
  logic pf_valid_r;

  // The word on instr_word_i is sampled at the end of the fetch phase.
  // During a redirect the fetch goes straight to the branch target, not to the old count.
  assign fetch_addr_o = redirect_r ? redirect_pc_r : pc_r;
  assign fetch_strobe_o = in_fetch;
  assign flush_o = kill_r;

  wire logic [3:0] ex_op = ir_r[FPP_OP_MSB:FPP_OP_LSB];
  wire logic ex_live = ir_valid_r && !kill_r;
  wire logic is_branch = (ex_op == FPP_OP_JMP) || (ex_op == FPP_OP_CALL) ||
                         (ex_op == FPP_OP_RET);

  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  logic [10:0] stack_r [STACK_DEPTH];
  logic [2:0] sp_r;
  wire logic [2:0] sp_top = (sp_r == 3'h0) ? 3'h0 : sp_r - 3'h1;

  fpp_alu_if alu_bus ();
  fpp_alu u_alu (.bus(alu_bus));
  logic [7:0] acc_r;
  logic zero_r;
  assign alu_bus.op = ex_op;
  assign alu_bus.acc = acc_r;
  assign alu_bus.imm = ir_r[7:0];
  assign acc_o = acc_r;
  assign zero_flag_o = zero_r;

  wire logic skip_taken = ex_live && !branch_pend_r && (ex_op == FPP_OP_SZ) && alu_bus.zero;

  // The fetched word waits in pf_r while the previous word executes, so fetch and
  // execution overlap and each word runs in the cycle after its fetch.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_r <= FPP_RESET_PC;
      pf_r <= FPP_NOP_WORD;
      pf_valid_r <= 1'b0;
    end else if (in_fetch) begin
      pf_r <= instr_word_i;
      pf_valid_r <= 1'b1;
      pc_r <= fetch_addr_o + 11'h001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ir_r <= FPP_NOP_WORD;
      ir_valid_r <= 1'b0;
    end else if (end_cycle) begin
      ir_r <= pf_r;
      ir_valid_r <= pf_valid_r;
    end
  end

  // Branch first cycle latches the target; second cycle redirects fetch.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      branch_pend_r <= 1'b0;
      target_r <= FPP_RESET_PC;
      redirect_r <= 1'b0;
      redirect_pc_r <= FPP_RESET_PC;
    end else begin
      if (in_exec && ex_live && is_branch && !branch_pend_r) begin
        branch_pend_r <= 1'b1;
        target_r <= (ex_op == FPP_OP_RET) ? stack_r[sp_top] : ir_r[10:0];
      end else if (end_cycle && branch_pend_r) begin
        branch_pend_r <= 1'b0;
      end
      if (end_cycle) begin
        redirect_r <= branch_pend_r;
        redirect_pc_r <= target_r;
      end else if (in_fetch) begin
        redirect_r <= 1'b0;
      end
    end
  end

  // A branch or taken skip turns the word already prefetched in its cycle into a dummy.
  // Fetch still runs in the dummy cycle, so the throughput loss is exactly one cycle.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kill_r <= 1'b0;
    end else if (end_cycle) begin
      kill_r <= skip_taken || (ex_live && is_branch);
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sp_r <= 3'h0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= FPP_RESET_PC;
      end
    end else if (in_exec && ex_live && !branch_pend_r) begin
      if (ex_op == FPP_OP_CALL && sp_r < 3'(STACK_DEPTH)) begin
        // This cycle's fetch already moved pc past the next word, so step back by one.
        stack_r[sp_r] <= pc_r - 11'h001;
        sp_r <= sp_r + 3'h1;
      end else if (ex_op == FPP_OP_RET && sp_r != 3'h0) begin
        sp_r <= sp_r - 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_r <= 8'h00;
      zero_r <= 1'b0;
    end else if (in_exec && ex_live && !is_branch && ex_op != FPP_OP_SZ &&
                 ex_op != FPP_OP_NOP) begin
      acc_r <= alu_bus.result;
      zero_r <= (alu_bus.result == 8'h00);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  phase_ring_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    in_fetch |=> !in_fetch [*3] ##1 in_fetch) else $error("phase ring broken");
  onehot_phase_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $onehot(phase_oh_r) && (phase_oh_r[0] == in_fetch)) else $error("phase not one-hot");
  pc_advance_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    in_fetch && !redirect_r |=> pc_r == $past(pc_r) + 11'h001) else $error("pc not advanced");
  pc_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !in_fetch |=> $stable(pc_r)) else $error("pc moved outside fetch");
  acc_exec_only_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !in_exec |=> $stable(acc_r)) else $error("acc changed outside execute");
  flush_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    kill_r && in_exec |=> $stable(acc_r) && $stable(sp_r)) else $error("flushed word ran");
  skip_dummy_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    skip_taken && end_cycle |=> kill_r) else $error("skip did not flush");
  branch_two_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    in_exec && ex_live && is_branch && !branch_pend_r |->
      ##2 (in_fetch && redirect_r && kill_r) ##4 (in_fetch && !redirect_r && !kill_r))
    else $error("branch not two cycles");
  alu_load_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    in_exec && ex_live && ex_op == FPP_OP_LDI |=> acc_r == $past(ir_r[7:0]))
    else $error("alu result lost");
  fetch_overlap_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    in_fetch |=> pf_r == $past(instr_word_i)) else $error("fetch missed");
  ir_handoff_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    end_cycle |=> ir_r == $past(pf_r)) else $error("prefetch not handed over");
endmodule // fpp_pipeline

// [sim/fpp_prog_mem.sv]
// Program memory model facing the pipeline's fetch port.
`timescale 1ns/1ps
module fpp_prog_mem
  import fpp_pkg::*;
(
  input wire logic [10:0] addr_i,
  input wire logic strobe_i,
  output logic [14:0] word_o
);
  logic [14:0] mem [0:2047];
  // The word is valid only while the fetch strobe selects the memory.
  // Outside it the model shows the inverse of the addressed word, so a late sample is caught.
  assign word_o = strobe_i ? mem[addr_i] : ~mem[addr_i];
endmodule // fpp_prog_mem

// [sim/four_phase_fetch_execute_pipeline_tb.sv]
// Self-checking testbench for the four phase fetch and execute pipeline.
`timescale 1ns/1ps
module four_phase_fetch_execute_pipeline_tb
  import fpp_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [14:0] instr_word_i;
  logic [10:0] fetch_addr_o;
  logic fetch_strobe_o;
  logic [3:0] phase_o;
  logic [7:0] acc_o;
  logic zero_flag_o;
  logic flush_o;
  int err_total = 0;
  int samples_checked = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  fpp_pipeline #(.STACK_DEPTH(6)) fpp_pipeline_i (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .instr_word_i(instr_word_i), .fetch_addr_o(fetch_addr_o),
    .fetch_strobe_o(fetch_strobe_o), .phase_o(phase_o), .acc_o(acc_o),
    .zero_flag_o(zero_flag_o), .flush_o(flush_o));
  fpp_prog_mem fpp_prog_mem_i (.addr_i(fetch_addr_o), .strobe_i(fetch_strobe_o),
    .word_o(instr_word_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input int a, input logic [3:0] op, input logic [7:0] imm);
    fpp_prog_mem_i.mem[a] = {op, 3'h0, imm};
  endtask

  // Memory is rewritten only while reset holds the pipeline still.
  task automatic hold_reset();
    @(negedge clk_sys_i);
    reset_n_i = 1'b0;
    for (int a = 0; a < 2048; a++) fpp_prog_mem_i.mem[a] = FPP_NOP_WORD;
  endtask

  task automatic release_reset();
    repeat (4) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
  endtask

  // Runs the program, watching for a value that only a wrong-path word could load.
  task automatic run_flow(input logic [7:0] bad, input logic [7:0] fin, input int fl, input bit ex);
    int nflush = 0;
    release_reset();
    for (int i = 0; i < 48; i++) begin
      @(negedge clk_sys_i);
      if (acc_o === bad) begin
        err_total++;
        $display("BAD acc expected not %0h seen %0h", bad, acc_o);
      end
      nflush += int'(flush_o === 1'b1);
    end
    if (ex) chk("flush cycles", 11'(fl), 11'(nflush));
    else chk("flush seen", 11'h001, 11'(nflush >= fl));
    chk("final acc", 11'(fin), 11'(acc_o));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_phases();
    hold_reset();
    release_reset();
    for (int i = 0; i < 12; i++) begin
      chk("phase", 11'(4'h1 << (i % 4)), 11'(phase_o));
      chk("strobe", 11'(i % 4 == 0), 11'(fetch_strobe_o));
      if (i % 4 == 0) chk("fetch addr", 11'(i / 4), fetch_addr_o);
      @(negedge clk_sys_i);
    end
  endtask

  task automatic test_alu();
    logic [3:0] ops [11] = '{FPP_OP_LDI, FPP_OP_ADD, FPP_OP_SUB, FPP_OP_AND, FPP_OP_OR,
      FPP_OP_XOR, FPP_OP_LDI, FPP_OP_RL, FPP_OP_RR, FPP_OP_INC, FPP_OP_DEC};
    logic [7:0] imms [11] = '{8'h81, 8'h80, 8'h02, 8'h3C, 8'h41, 8'h7D, 8'h96, 8'h00,
      8'h00, 8'h00, 8'h00};
    logic [7:0] accs [11] = '{8'h81, 8'h01, 8'hFF, 8'h3C, 8'h7D, 8'h00, 8'h96, 8'h2D,
      8'h96, 8'h97, 8'h96};
    hold_reset();
    for (int k = 0; k < 11; k++) wr(k, ops[k], imms[k]);
    release_reset();
    // A word fetched in one cycle has its result visible after the execute phase of the next cycle.
    repeat (8) @(negedge clk_sys_i);
    for (int k = 0; k < 11; k++) begin
      chk("acc", 11'(accs[k]), 11'(acc_o));
      if (ops[k] != FPP_OP_LDI) chk("zero", 11'(accs[k] == 8'h00), 11'(zero_flag_o));
      repeat (4) @(negedge clk_sys_i);
    end
  endtask

  task automatic test_jump();
    hold_reset();
    wr(0, FPP_OP_LDI, 8'h11);
    fpp_prog_mem_i.mem[1] = {FPP_OP_JMP, 11'h010};
    for (int a = 2; a < 16; a++) wr(a, FPP_OP_LDI, 8'h22);
    wr(16, FPP_OP_LDI, 8'h40);
    wr(17, FPP_OP_INC, 8'h00);
    run_flow(8'h22, 8'h41, FPP_PHASES, 1'b0);
  endtask

  // A call and its return each cost one dummy cycle; the return lands after the call.
  task automatic test_call();
    hold_reset();
    wr(0, FPP_OP_LDI, 8'h01);
    fpp_prog_mem_i.mem[1] = {FPP_OP_CALL, 11'h020};
    wr(2, FPP_OP_INC, 8'h00);
    wr(32, FPP_OP_LDI, 8'h40);
    wr(33, FPP_OP_RET, 8'h00);
    wr(34, FPP_OP_LDI, 8'h22);
    run_flow(8'h22, 8'h41, 2 * FPP_PHASES, 1'b1);
  endtask

  task automatic test_skip();
    hold_reset();
    wr(0, FPP_OP_LDI, 8'h00);
    wr(1, FPP_OP_SZ, 8'h00);
    wr(2, FPP_OP_LDI, 8'h77);
    wr(3, FPP_OP_LDI, 8'h12);
    run_flow(8'h77, 8'h12, FPP_PHASES, 1'b1);
    hold_reset();
    wr(0, FPP_OP_LDI, 8'h05);
    wr(1, FPP_OP_SZ, 8'h00);
    wr(2, FPP_OP_LDI, 8'h77);
    run_flow(8'h22, 8'h77, 0, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The scenarios need well under 2000 cycles; the limit leaves ample margin.
  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  initial begin
    test_phases();
    test_alu();
    test_jump();
    test_call();
    test_skip();
    complete_run();
  end
endmodule // four_phase_fetch_execute_pipeline_tb
